// File: design/svr_pkg.sv
package svr_pkg;
    // Clock rate and derived counts
    localparam int CLK_KHZ        = 200000;
    localparam int HOLD_TIME_MS   = 150;
    localparam int WD_PERIOD_MS   = 1650;
    localparam int GRACE_TIME_NS  = 12000;
    localparam int FILT_TIME_NS   = 100;
    localparam int HOLD_CYC       = HOLD_TIME_MS * CLK_KHZ;
    localparam int WD_CYC         = WD_PERIOD_MS * CLK_KHZ;
    localparam int GRACE_CYC      = GRACE_TIME_NS * (CLK_KHZ / 1000) / 1000;
    localparam int FILT_CYC       = (FILT_TIME_NS * (CLK_KHZ / 1000) + 999) / 1000;

    // Filtered input lanes
    localparam int LANES          = 5;
    localparam int LN_SUPPLY_LOW  = 0;
    localparam int LN_MANUAL_N    = 1;
    localparam int LN_AUX_OK      = 2;
    localparam int LN_BACKUP_GT   = 3;
    localparam int LN_MAIN_GT     = 4;
    // Reset image: supply low, manual idle high, aux ok, main preferred
    localparam logic [4:0] LANE_RST = 5'h17;

    localparam int CNT_W          = 32;
    localparam int GRACE_W        = 12;
    localparam int FILT_W         = 5;

    typedef enum logic [1:0] {CE_PASS, CE_GRACE, CE_BLOCK} svr_ce_st_t;
endpackage

// File: design/svr_lane_if.sv
`timescale 1ns/1ps
`default_nettype none
interface svr_lane_if;
    logic       clk;
    logic       rst_n;
    logic [4:0] raw;
    logic [4:0] clean;
    modport filt (input clk, input rst_n, input raw, output clean);
    modport user (output clk, output rst_n, output raw, input clean);
endinterface
`default_nettype wire

// File: design/svr_lane_filter.sv
`timescale 1ns/1ps
`default_nettype none
module svr_lane_filter (
    svr_lane_if.filt lanes  // Raw pins in, clean levels out
);
    typedef struct packed {
        logic [4:0]      s1;
        logic [4:0]      s2;
        logic [4:0]      s3;
        logic [4:0][4:0] cnt;
        logic [4:0]      clean;
    } svr_filt_st_t;

    svr_filt_st_t st_q;
    svr_filt_st_t st_d;

    // Three-stage sync, then level must hold FILT_CYC before acceptance
    always_comb begin
        st_d    = st_q;
        st_d.s1 = lanes.raw;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < svr_pkg::LANES; i++) begin
            if (st_q.s2[i] == st_q.s3[i] && st_q.s3[i] != st_q.clean[i]) begin // RULE_18
                if (st_q.cnt[i] == 5'(svr_pkg::FILT_CYC - 1)) begin
                    st_d.clean[i] = st_q.s3[i];
                    st_d.cnt[i]   = 5'h00;
                end else begin
                    st_d.cnt[i] = st_q.cnt[i] + 5'h01;
                end
            end else begin
                st_d.cnt[i] = 5'h00; // Short glitch restarts the wait
            end
        end
    end

    // Registers
    always_ff @(posedge lanes.clk or negedge lanes.rst_n) begin
        if (!lanes.rst_n) begin
            st_q       <= '0;
            st_q.s1    <= svr_pkg::LANE_RST;
            st_q.s2    <= svr_pkg::LANE_RST;
            st_q.s3    <= svr_pkg::LANE_RST;
            st_q.clean <= svr_pkg::LANE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign lanes.clean = st_q.clean;
endmodule // svr_lane_filter
`default_nettype wire

// File: design/svr_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE_01 - Reset held while any level cause active
// RULE_02 - Watchdog expiry gives one hold-time pulse
// RULE_03 - Reset stretched by hold time after cause
// RULE_04 - Active-high and active-low reset outputs match
// RULE_05 - Manual reset low asserts, then hold time
// RULE_06 - Stuck kick input longer than period resets
// RULE_07 - Watchdog cleared by reset or kick edge
// RULE_08 - Backup flag high in battery mode
// RULE_09 - Auxiliary sense low asserts, then hold time
// RULE_10 - Rail from main unless supply under threshold
// RULE_11 - Hysteretic switch between main and backup
// RULE_12 - Gated enable low only outside reset
// RULE_13 - Enable low at reset kept for grace
// RULE_14 - Forced-high enable stays high until release
// RULE_15 - Hold time at least minimum timeout
// RULE_16 - Processor kick pulses meet minimum width
// RULE_17 - Counters with lengths as parameters
// RULE_18 - Sync and glitch-filter manual and comparators
// RULE_19 - Processor kicks faster than watchdog period
module svr_supervisor #(
    parameter int HOLD_CYC = svr_pkg::HOLD_CYC, // Reset hold time in cycles
    parameter int WD_CYC   = svr_pkg::WD_CYC    // Watchdog period in cycles
) (
    input  wire logic clock,            // 200 MHz timebase
    input  wire logic rstn,             // Async reset, active low
    input  wire logic supply_low_in,    // Main supply under supply_threshold
    input  wire logic manual_reset_n,   // Manual reset, active low
    input  wire logic aux_sense_ok_in,  // Aux sense above reference
    input  wire logic backup_gt_main,   // Backup exceeds main by margin
    input  wire logic main_gt_backup,   // Main exceeds backup by margin
    input  wire logic watchdog_kick_in, // Watchdog kick from processor
    input  wire logic ce_in_n,          // Chip enable from processor
    output logic      reset_out,        // Reset, active high
    output logic      reset_out_n,      // Reset, active low
    output logic      ce_out_n,         // Gated chip enable to memory
    output logic      on_backup_flag    // Rail fed from backup_supply
);
    // Release flops live outside the struct: they run on the raw reset
    typedef struct packed {
        logic [2:0]                   kick_s;
        logic [2:0]                   ce_s;
        logic                         kick_lvl;
        logic                         ce_lvl;
        logic [svr_pkg::CNT_W-1:0]    hold_cnt;
        logic [svr_pkg::CNT_W-1:0]    wd_cnt;
        logic [svr_pkg::GRACE_W-1:0]  grace_cnt;
        svr_pkg::svr_ce_st_t          ce_st;
        logic                         rst;
        logic                         rst_n;
        logic                         ce_out_n;
        logic                         on_backup;
    } svr_main_st_t;

    svr_main_st_t st_q;
    svr_main_st_t st_d;
    svr_lane_if   lanes ();

    logic [1:0] rsync_q;
    logic       srst_n;
    logic       cause;
    logic       kick_edge;
    logic       wd_exp;

    // Settle check on a three-stage sync chain
    function automatic logic svr_settled(input logic [2:0] chain);
        return chain[1] == chain[2];
    endfunction

    // Reset released through two flops; assertion stays asynchronous
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rsync_q <= 2'h0;
        end else begin
            rsync_q <= {rsync_q[0], 1'b1};
        end
    end
    assign srst_n = rsync_q[1]; // Only the second flop feeds the design

    // Slow pins go through the shared sync and glitch filter
    assign lanes.clk   = clock;
    assign lanes.rst_n = srst_n;
    assign lanes.raw   = {main_gt_backup, backup_gt_main, aux_sense_ok_in, manual_reset_n, supply_low_in};

    svr_lane_filter u_filt (
        .lanes (lanes)
    );

    // Level causes combined
    assign cause = lanes.clean[svr_pkg::LN_SUPPLY_LOW]    // RULE_01
                 | ~lanes.clean[svr_pkg::LN_MANUAL_N]     // RULE_05
                 | ~lanes.clean[svr_pkg::LN_AUX_OK];      // RULE_09
    // Kick edge counts once stages two and three agree
    assign kick_edge = svr_settled(st_q.kick_s) && (st_q.kick_s[2] != st_q.kick_lvl); // RULE_07
    // Expiry blocked in reset, so a pulse cannot retrigger itself
    assign wd_exp    = !st_q.rst && (st_q.wd_cnt == 32'(WD_CYC - 1)); // RULE_06

    always_comb begin
        st_d        = st_q;
        st_d.kick_s = {st_q.kick_s[1:0], watchdog_kick_in};
        st_d.ce_s   = {st_q.ce_s[1:0], ce_in_n};
        // Levels taken only once stages two and three agree
        if (svr_settled(st_q.kick_s)) begin
            st_d.kick_lvl = st_q.kick_s[2];
        end
        if (svr_settled(st_q.ce_s)) begin
            st_d.ce_lvl = st_q.ce_s[2];
        end

        // Hold counter reloads on any cause, counts down after
        // Reload every cause cycle, so hold counts from the last one
        if (cause || wd_exp) begin
            st_d.hold_cnt = 32'(HOLD_CYC); // RULE_03 RULE_15 RULE_17
        end else if (st_q.hold_cnt != 32'h0) begin
            st_d.hold_cnt = st_q.hold_cnt - 32'h1;
        end
        // Watchdog pulse ends by itself once the hold time runs out
        st_d.rst   = (st_d.hold_cnt != 32'h0); // RULE_02 RULE_03
        st_d.rst_n = ~st_d.rst;                // RULE_04

        // Watchdog counter; wraps only through the reset it causes
        // Width covers the default period with room to spare
        if (st_q.rst || kick_edge) begin
            st_d.wd_cnt = 32'h0; // RULE_07
        end else begin
            st_d.wd_cnt = st_q.wd_cnt + 32'h1; // RULE_17
        end

        // Supply selection with comparator hysteresis
        // Neither comparator set keeps the last choice
        if (!lanes.clean[svr_pkg::LN_SUPPLY_LOW]) begin
            st_d.on_backup = 1'b0; // RULE_10
        end else if (lanes.clean[svr_pkg::LN_BACKUP_GT]) begin
            st_d.on_backup = 1'b1; // RULE_11
        end else if (lanes.clean[svr_pkg::LN_MAIN_GT]) begin
            st_d.on_backup = 1'b0; // RULE_11
        end

        // Chip-enable gating; decisions follow the registered reset
        case (st_q.ce_st)
            svr_pkg::CE_PASS: begin
                // A reset due next cycle must not meet a fresh low edge
                st_d.ce_out_n = st_q.ce_lvl || (st_d.rst && st_q.ce_out_n); // RULE_12
                if (st_q.rst) begin
                    // Grace only if the memory was really selected
                    if (!st_q.ce_out_n) begin
                        st_d.ce_st     = svr_pkg::CE_GRACE; // RULE_13
                        st_d.grace_cnt = 12'(svr_pkg::GRACE_CYC);
                        st_d.ce_out_n  = 1'b0;
                    end else begin
                        st_d.ce_st    = svr_pkg::CE_BLOCK; // RULE_14
                        st_d.ce_out_n = 1'b1;
                    end
                end
            end
            svr_pkg::CE_GRACE: begin
                st_d.grace_cnt = st_q.grace_cnt - 12'h001;
                if (!st_q.rst) begin
                    st_d.ce_st    = svr_pkg::CE_PASS;
                    st_d.ce_out_n = st_q.ce_lvl;
                end else if (st_q.ce_lvl || st_q.grace_cnt <= 12'h001) begin
                    st_d.ce_st    = svr_pkg::CE_BLOCK; // RULE_13
                    st_d.ce_out_n = 1'b1;
                end
            end
            svr_pkg::CE_BLOCK: begin
                st_d.ce_out_n = 1'b1; // RULE_14
                if (!st_q.rst) begin
                    st_d.ce_st    = svr_pkg::CE_PASS;
                    st_d.ce_out_n = st_q.ce_lvl || st_d.rst; // RULE_12
                end
            end
            default: begin
                st_d.ce_st    = svr_pkg::CE_BLOCK;
                st_d.ce_out_n = 1'b1;
            end
        endcase
    end

    // Main state; memory kept deselected and reset asserted at power-up
    always_ff @(posedge clock or negedge srst_n) begin
        if (!srst_n) begin
            st_q.kick_s    <= 3'h0;
            st_q.ce_s      <= 3'h7;
            st_q.kick_lvl  <= 1'b0;
            st_q.ce_lvl    <= 1'b1;
            // Supply-low lane image reloads this count, keeping reset high until the lanes settle
            st_q.hold_cnt  <= 32'h0000_0001;
            st_q.wd_cnt    <= 32'h0;
            st_q.grace_cnt <= 12'h000;
            st_q.ce_st     <= svr_pkg::CE_BLOCK;
            st_q.rst       <= 1'b1;
            st_q.rst_n     <= 1'b0;
            st_q.ce_out_n  <= 1'b1;
            st_q.on_backup <= 1'b0;
        end else begin
            st_q.kick_s    <= st_d.kick_s;
            st_q.ce_s      <= st_d.ce_s;
            st_q.kick_lvl  <= st_d.kick_lvl;
            st_q.ce_lvl    <= st_d.ce_lvl;
            st_q.hold_cnt  <= st_d.hold_cnt;
            st_q.wd_cnt    <= st_d.wd_cnt;
            st_q.grace_cnt <= st_d.grace_cnt;
            st_q.ce_st     <= st_d.ce_st;
            st_q.rst       <= st_d.rst;
            st_q.rst_n     <= st_d.rst_n;
            st_q.ce_out_n  <= st_d.ce_out_n;
            st_q.on_backup <= st_d.on_backup;
        end
    end

    // Outputs straight from flops
    // Both polarities have their own flop, so they never skew
    assign reset_out      = st_q.rst;       // RULE_04
    assign reset_out_n    = st_q.rst_n;     // RULE_04
    assign ce_out_n       = st_q.ce_out_n;
    assign on_backup_flag = st_q.on_backup; // RULE_08
endmodule // svr_supervisor
`default_nettype wire

// File: tb/svr_sva.sv
`timescale 1ns/1ps
`default_nettype none
module svr_sva #(
    parameter int HOLD_CYC = 50, // Hold cycles
    parameter int WD_CYC   = 400 // Watchdog cycles
) (
    input wire logic clock,            // Timebase
    input wire logic rstn,             // Async reset
    input wire logic supply_low_in,    // Supply low
    input wire logic manual_reset_n,   // Manual reset
    input wire logic aux_sense_ok_in,  // Aux sense ok
    input wire logic backup_gt_main,   // Backup higher
    input wire logic main_gt_backup,   // Main higher
    input wire logic watchdog_kick_in, // Kick
    input wire logic ce_in_n,          // Enable in
    input wire logic reset_out,        // Reset high
    input wire logic reset_out_n,      // Reset low
    input wire logic ce_out_n,         // Enable out
    input wire logic on_backup_flag    // Backup flag
);
    logic cause;
    int   run_q, quiet_q, high_q, kick_q, grace_q;
    assign cause = supply_low_in | ~manual_reset_n | ~aux_sense_ok_in;
    // Run lengths; int cannot wrap within one run
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            run_q <= 0;
            quiet_q <= 0;
            high_q <= 0;
            kick_q <= 0;
            grace_q <= 0;
        end else begin
            run_q <= cause ? run_q + 1 : 0;
            quiet_q <= cause ? 0 : quiet_q + 1;
            high_q <= reset_out ? high_q + 1 : 0;
            kick_q <= (reset_out || $changed(watchdog_kick_in)) ? 0 : kick_q + 1;
            grace_q <= (reset_out && !ce_out_n) ? grace_q + 1 : 0;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // Margins cover sync and filter latency only
    pol_match_a: assert property (reset_out_n == !reset_out) else $error("polarity");
    cause_hold_a: assert property (run_q > 28 |-> reset_out) else $error("no reset");
    hold_time_a: assert property ($fell(reset_out) |-> quiet_q > HOLD_CYC) else $error("short hold");
    wd_pulse_a: assert property ($fell(reset_out) && quiet_q > 300
        |-> high_q >= HOLD_CYC && high_q <= HOLD_CYC + 2) else $error("pulse length");
    wd_bound_a: assert property (kick_q <= WD_CYC + 10) else $error("no expiry");
    ce_gate_a: assert property ($fell(ce_out_n) |-> !reset_out && !$past(ce_in_n, 2)) else $error("gate");
    grace_a: assert property (grace_q <= svr_pkg::GRACE_CYC + 3) else $error("grace");
    ce_block_a: assert property (reset_out && $past(reset_out) && $past(ce_out_n) |-> ce_out_n) else $error("block");
    backup_a: assert property ($rose(on_backup_flag)
        |-> $past(supply_low_in, 2) && $past(backup_gt_main, 2)) else $error("backup");
    cover property ($fell(reset_out) && quiet_q > 300);
    cover property (grace_q == 100);
    cover property ($rose(on_backup_flag));
endmodule // svr_sva
bind svr_supervisor svr_sva #(.HOLD_CYC(HOLD_CYC), .WD_CYC(WD_CYC)) chk (.clock(clock), .rstn(rstn),
    .supply_low_in(supply_low_in), .manual_reset_n(manual_reset_n), .aux_sense_ok_in(aux_sense_ok_in),
    .backup_gt_main(backup_gt_main), .main_gt_backup(main_gt_backup), .watchdog_kick_in(watchdog_kick_in),
    .ce_in_n(ce_in_n), .reset_out(reset_out), .reset_out_n(reset_out_n), .ce_out_n(ce_out_n),
    .on_backup_flag(on_backup_flag));
`default_nettype wire

// File: tb/svr_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module svr_cpu_model #(
    parameter int KICK_CYC = 60 // Cycles per kick level
) (
    input  wire logic clock,  // Bus clock
    input  wire logic kick_en, // Service watchdog
    input  wire logic ce_req,  // Memory access wanted
    output logic      kick,    // Watchdog kick
    output logic      ce_n     // Chip enable
);
    int n_q;
    initial begin
        kick = 1'b0;
        ce_n = 1'b1;
        n_q = 0;
    end
    // Levels far over 100 ns, period well inside the watchdog
    always @(negedge clock) begin
        ce_n <= !ce_req;
        n_q <= (n_q == KICK_CYC - 1) ? 0 : n_q + 1;
        if (kick_en && n_q == 0) begin
            kick <= !kick;
        end
    end
endmodule // svr_cpu_model
`default_nettype wire

// File: tb/supervisor_reset_ce_gating_bench.sv
`timescale 1ns/1ps
`default_nettype none
module supervisor_reset_ce_gating_bench;
    localparam int HOLD = 50;
    localparam int WD = 400;
    logic clock, rstn, supply_low_in, manual_reset_n, aux_sense_ok_in, backup_gt_main, main_gt_backup;
    logic kick_en, ce_req, reset_out, reset_out_n, ce_out_n, on_backup_flag;
    wire logic watchdog_kick_in, ce_in_n;
    int fails = 0;
    int n_tests = 0;
    svr_supervisor #(.HOLD_CYC(HOLD), .WD_CYC(WD)) uut (.clock(clock), .rstn(rstn),
        .supply_low_in(supply_low_in), .manual_reset_n(manual_reset_n), .aux_sense_ok_in(aux_sense_ok_in),
        .backup_gt_main(backup_gt_main), .main_gt_backup(main_gt_backup), .watchdog_kick_in(watchdog_kick_in),
        .ce_in_n(ce_in_n), .reset_out(reset_out), .reset_out_n(reset_out_n), .ce_out_n(ce_out_n),
        .on_backup_flag(on_backup_flag));
    svr_cpu_model cpu (.clock(clock), .kick_en(kick_en), .ce_req(ce_req), .kick(watchdog_kick_in), .ce_n(ce_in_n));
    // 200 MHz
    always #2.5 clock = ~clock;
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1) begin
            fails++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask
    // Bounded wait for a reset level, returns cycles spent
    task automatic wait_rst(input logic v, output int n);
        n = 0;
        while (reset_out !== v && n < 3000) begin
            n++;
            cyc(1);
        end
    endtask
    task automatic set_cause(input int s, input logic v);
        case (s)
            0: supply_low_in = v;
            1: manual_reset_n = !v;
            default: aux_sense_ok_in = !v;
        endcase
    endtask
    task automatic t_cause(input int s);
        set_cause(s, 1'b1);
        cyc(10);
        set_cause(s, 1'b0);
        cyc(30);
        chk(reset_out === 1'b0, "glitch");
        set_cause(s, 1'b1);
        cyc(40);
        chk(reset_out === 1'b1 && reset_out_n === 1'b0, "assert");
        set_cause(s, 1'b0);
        cyc(60);
        chk(reset_out === 1'b1, "hold");
        cyc(30);
        chk(reset_out === 1'b0 && reset_out_n === 1'b1, "release");
        $display("done cause %0d", s);
    endtask
    task automatic t_watchdog();
        int n;
        kick_en = 1'b0;
        wait_rst(1'b1, n);
        chk(n >= WD - 70 && n <= WD + 10, "expiry");
        wait_rst(1'b0, n);
        chk(n == HOLD, "pulse");
        wait_rst(1'b1, n);
        chk(n >= WD && n <= WD + 10, "repeat");
        kick_en = 1'b1;
        wait_rst(1'b0, n);
        cyc(1000);
        chk(reset_out === 1'b0, "kicked");
        $display("done watchdog");
    endtask
    task automatic t_ce();
        ce_req = 1'b1;
        cyc(10);
        chk(ce_out_n === 1'b0, "pass");
        manual_reset_n = 1'b0;
        cyc(40);
        chk(reset_out === 1'b1 && ce_out_n === 1'b0, "grace");
        cyc(svr_pkg::GRACE_CYC);
        chk(ce_out_n === 1'b1, "grace end");
        ce_req = 1'b0;
        cyc(10);
        ce_req = 1'b1;
        cyc(10);
        chk(ce_out_n === 1'b1, "blocked");
        manual_reset_n = 1'b1;
        cyc(90);
        chk(ce_out_n === 1'b0, "reopen");
        manual_reset_n = 1'b0;
        cyc(40);
        ce_req = 1'b0;
        cyc(10);
        chk(ce_out_n === 1'b1, "cut short");
        manual_reset_n = 1'b1;
        cyc(90);
        chk(ce_out_n === 1'b1 && reset_out === 1'b0, "idle");
        $display("done gating");
    endtask
    task automatic t_backup();
        supply_low_in = 1'b1;
        backup_gt_main = 1'b1;
        cyc(40);
        chk(on_backup_flag === 1'b1 && reset_out === 1'b1, "to backup");
        backup_gt_main = 1'b0;
        cyc(40);
        chk(on_backup_flag === 1'b1, "hysteresis");
        main_gt_backup = 1'b1;
        cyc(40);
        chk(on_backup_flag === 1'b0, "to main");
        main_gt_backup = 1'b0;
        backup_gt_main = 1'b1;
        cyc(40);
        chk(on_backup_flag === 1'b1, "again");
        supply_low_in = 1'b0;
        cyc(40);
        chk(on_backup_flag === 1'b0, "supply ok");
        backup_gt_main = 1'b0;
        cyc(100);
        $display("done backup");
    endtask
    task automatic stop_test();
        $display("tests %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Tests need about 6000 cycles
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        $display("mismatch %0t timeout", $time);
        stop_test();
    end
    initial begin
        clock = 1'b0;
        rstn = 1'b0;
        supply_low_in = 1'b0;
        manual_reset_n = 1'b1;
        aux_sense_ok_in = 1'b1;
        backup_gt_main = 1'b0;
        main_gt_backup = 1'b0;
        kick_en = 1'b1;
        ce_req = 1'b0;
        cyc(2);
        rstn = 1'b1;
        cyc(100);
        chk(reset_out === 1'b0, "power up");
        for (int s = 0; s < 3; s++) t_cause(s);
        t_watchdog();
        t_ce();
        t_backup();
        stop_test();
    end
endmodule // supervisor_reset_ce_gating_bench
`default_nettype wire
